// ### src/eeprom_seq_pkg.sv
// Constants and types for the serial EEPROM command sequencer.
// Assumes a 50 MHz system clock that samples every link pin.
package eeprom_seq_pkg;
    localparam int ADDR_W     = 9;
    localparam int DATA_W     = 8;
    localparam int MEM_DEPTH  = 512;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W     = ADDR_W + DATA_W;

    // Opcodes, most significant bit first on the wire
    localparam logic [7:0] OP_LATCH_SET    = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_RW_MASK      = 8'hf7;
    localparam logic [7:0] OP_READ         = 8'h03;
    localparam logic [7:0] OP_WRITE        = 8'h02;
    localparam int         OP_ADDR_TOP_POS = 3;

    // Status byte layout
    localparam int         ST_BUSY_POS    = 0;
    localparam int         ST_LATCH_POS   = 1;
    localparam int         ST_PROT_LO_POS = 2;
    localparam logic [7:0] ST_BUSY_FILL   = 8'hff;

    // Block protect settings
    localparam logic [1:0]        PROT_NONE    = 2'h0;
    localparam logic [1:0]        PROT_QUARTER = 2'h1;
    localparam logic [1:0]        PROT_HALF    = 2'h2;
    localparam logic [ADDR_W-1:0] QUARTER_BASE = 9'h180;
    localparam logic [ADDR_W-1:0] HALF_BASE    = 9'h100;

    // Pin synchroniser reset values {wp_n, hold_n, si, sck, cs_n}
    localparam logic [4:0] PIN_RESET = 5'h18;

    // Self-timed write length
    localparam int CLK_HZ         = 50_000_000;
    localparam int WRITE_CYCLE_MS = 10;
    localparam int WRITE_CYCLES   = WRITE_CYCLE_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_OPC    = 3'h1,
        ST_ADDR   = 3'h3,
        ST_RDATA  = 3'h2,
        ST_WDATA  = 3'h6,
        ST_SWDATA = 3'h7,
        ST_SREAD  = 3'h5,
        ST_IGNORE = 3'h4
    } seq_state_e;
endpackage : eeprom_seq_pkg

// ### src/spi_eeprom_command_sequencer.sv
// Serial EEPROM command sequencer with write FIFO and self-timed write engine.
// Assumes link pins are asynchronous to ref_clk and much slower than it.
`timescale 1ns/1ps

module write_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    // DEPTH must be a power of two so the pointers wrap naturally
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_q + PW'(push);
            rd_q  <= rd_q + PW'(pop);
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : write_fifo

module spi_eeprom_command_sequencer #(
    parameter int WRITE_CYCLES = eeprom_seq_pkg::WRITE_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic hold_n,
    input  wire logic wp_n,
    output logic      so_out,
    output logic      so_oe,
    output logic      write_busy_flag,
    output logic      write_latch_flag
);
    localparam int TW = $clog2(WRITE_CYCLES + 1);

    logic [1:0] rst_q;
    logic       rst_n;
    logic [4:0] pin_m_q;
    logic [4:0] pin_s_q;
    logic       cs_s, sck_s, si_s, hold_s, wp_s;
    logic       cs_prev_q, sck_prev_q;
    logic       cs_fall, cs_rise, sck_fall, sck_rise, opc_done;

    eeprom_seq_pkg::seq_state_e state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q, rx_next;
    logic [8:0] addr_q;
    logic       is_write_q, byte_done_q, wp_low_q;
    logic [3:0] page_valid_q;
    logic [7:0] page_buf_q [4];
    logic [7:0] sw_data_q;
    logic [7:0] tx_q, status_byte;
    logic [2:0] tx_cnt_q;
    logic       so_q, so_oe_q, out_active_q;
    logic       wel_q, busy_q, timer_done_q, load_active_q, sts_pend_q;
    logic [1:0] bp_q, load_idx_q;
    logic [TW-1:0] timer_q;
    logic       prot_hit, commit_arr, commit_sts, start, busy_end;
    logic       fifo_in_valid, fifo_in_ready, fifo_out_valid;
    logic [eeprom_seq_pkg::FIFO_W-1:0] fifo_in_data, fifo_out_data;
    logic [7:0] mem_q [eeprom_seq_pkg::MEM_DEPTH];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Two-flop synchroniser for all pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_m_q <= eeprom_seq_pkg::PIN_RESET;
            pin_s_q <= eeprom_seq_pkg::PIN_RESET;
        end else begin
            pin_m_q <= {wp_n, hold_n, si, sck, cs_n};
            pin_s_q <= pin_m_q;
        end
    end
    assign {wp_s, hold_s, si_s, sck_s, cs_s} = pin_s_q;

    // Select low at reset is not a fall: a fresh fall is needed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_prev_q  <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            cs_prev_q  <= cs_s;
            sck_prev_q <= sck_s;
        end
    end
    assign cs_fall  = ~cs_s & cs_prev_q;
    assign cs_rise  = cs_s & ~cs_prev_q;
    // Clock edges are ignored while paused
    assign sck_fall = ~sck_s & sck_prev_q & ~cs_s & ~cs_fall & hold_s;
    assign sck_rise = sck_s & ~sck_prev_q & ~cs_s & hold_s;
    assign rx_next  = {rx_q[6:0], si_s};
    assign opc_done = sck_fall & (state_q == eeprom_seq_pkg::ST_OPC) & (bit_cnt_q == 3'h7);

    always_comb begin
        status_byte = '0;
        status_byte[eeprom_seq_pkg::ST_PROT_LO_POS +: 2] = bp_q;
        status_byte[eeprom_seq_pkg::ST_LATCH_POS] = wel_q;
        if (busy_q) begin
            status_byte = eeprom_seq_pkg::ST_BUSY_FILL;
        end
    end

    always_comb begin
        case (bp_q)
            eeprom_seq_pkg::PROT_NONE:    prot_hit = 1'b0;
            eeprom_seq_pkg::PROT_QUARTER: prot_hit = (addr_q >= eeprom_seq_pkg::QUARTER_BASE);
            eeprom_seq_pkg::PROT_HALF:    prot_hit = (addr_q >= eeprom_seq_pkg::HALF_BASE);
            default:                      prot_hit = 1'b1;
        endcase
    end

    // Commit only on a byte-aligned rise with the protect pin high; array writes also need an unprotected range
    assign commit_arr = cs_rise & (state_q == eeprom_seq_pkg::ST_WDATA) & (bit_cnt_q == 3'h0)
                      & byte_done_q & wp_s & ~wp_low_q & ~prot_hit;
    assign commit_sts = cs_rise & (state_q == eeprom_seq_pkg::ST_SWDATA) & (bit_cnt_q == 3'h0)
                      & byte_done_q & wp_s & ~wp_low_q;
    assign start      = commit_arr | commit_sts;

    chk_bit_aligned:  assert property (cs_rise && bit_cnt_q != 3'h0 |-> !start)
        else $error("write started off a byte boundary");
    chk_wp_blocks:    assert property (cs_rise && !wp_s |-> !start)
        else $error("write started with protect pin low");
    chk_range_guard:  assert property (commit_arr |-> !prot_hit && wel_q)
        else $error("array write committed into protected range or without latch");

    // Command sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= eeprom_seq_pkg::ST_IDLE;
            bit_cnt_q    <= 3'h0;
            rx_q         <= 8'h00;
            addr_q       <= 9'h000;
            is_write_q   <= 1'b0;
            byte_done_q  <= 1'b0;
            wp_low_q     <= 1'b0;
            page_valid_q <= 4'h0;
            page_buf_q   <= '{default: 8'h00};
            sw_data_q    <= 8'h00;
            tx_q         <= 8'h00;
            tx_cnt_q     <= 3'h0;
            so_q         <= 1'b0;
            out_active_q <= 1'b0;
        end else if (cs_fall) begin
            state_q      <= eeprom_seq_pkg::ST_OPC;
            bit_cnt_q    <= 3'h0;
            byte_done_q  <= 1'b0;
            wp_low_q     <= ~wp_s;
            out_active_q <= 1'b0;
        end else if (cs_s) begin
            state_q      <= eeprom_seq_pkg::ST_IDLE;
            out_active_q <= 1'b0;
        end else begin
            if (!wp_s) begin
                wp_low_q <= 1'b1;
            end
            if (sck_fall) begin
                rx_q      <= rx_next;
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    case (state_q)
                        eeprom_seq_pkg::ST_OPC: begin
                            state_q <= eeprom_seq_pkg::ST_IGNORE;
                            if (rx_next == eeprom_seq_pkg::OP_STATUS_READ) begin
                                state_q  <= eeprom_seq_pkg::ST_SREAD;
                                tx_q     <= status_byte;
                                tx_cnt_q <= 3'h0;
                            end else if (rx_next == eeprom_seq_pkg::OP_STATUS_WRITE
                                         && wel_q && !busy_q) begin
                                state_q <= eeprom_seq_pkg::ST_SWDATA;
                            end else if (!busy_q && ((rx_next & eeprom_seq_pkg::OP_RW_MASK)
                                         == eeprom_seq_pkg::OP_READ)) begin
                                state_q    <= eeprom_seq_pkg::ST_ADDR;
                                is_write_q <= 1'b0;
                                addr_q[8]  <= rx_next[eeprom_seq_pkg::OP_ADDR_TOP_POS];
                            end else if (wel_q && !busy_q
                                         && ((rx_next & eeprom_seq_pkg::OP_RW_MASK)
                                         == eeprom_seq_pkg::OP_WRITE)) begin
                                state_q    <= eeprom_seq_pkg::ST_ADDR;
                                is_write_q <= 1'b1;
                                addr_q[8]  <= rx_next[eeprom_seq_pkg::OP_ADDR_TOP_POS];
                            end
                        end
                        eeprom_seq_pkg::ST_ADDR: begin
                            if (is_write_q) begin
                                state_q      <= eeprom_seq_pkg::ST_WDATA;
                                addr_q[7:0]  <= rx_next;
                                page_valid_q <= 4'h0;
                            end else begin
                                state_q  <= eeprom_seq_pkg::ST_RDATA;
                                tx_q     <= mem_q[{addr_q[8], rx_next}];
                                tx_cnt_q <= 3'h0;
                                addr_q   <= {addr_q[8], rx_next} + 9'h001;
                            end
                        end
                        eeprom_seq_pkg::ST_WDATA: begin
                            page_buf_q[addr_q[1:0]]   <= rx_next;
                            page_valid_q[addr_q[1:0]] <= 1'b1;
                            addr_q[1:0]               <= addr_q[1:0] + 2'h1;
                            byte_done_q               <= 1'b1;
                        end
                        eeprom_seq_pkg::ST_SWDATA: begin
                            sw_data_q   <= rx_next;
                            byte_done_q <= 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            if (sck_rise && (state_q == eeprom_seq_pkg::ST_RDATA
                             || state_q == eeprom_seq_pkg::ST_SREAD)) begin
                so_q         <= tx_q[7];
                tx_q         <= {tx_q[6:0], 1'b0};
                tx_cnt_q     <= tx_cnt_q + 3'h1;
                out_active_q <= 1'b1;
                if (tx_cnt_q == 3'h7) begin
                    if (state_q == eeprom_seq_pkg::ST_RDATA) begin
                        tx_q   <= mem_q[addr_q];
                        addr_q <= addr_q + 9'h001;
                    end else begin
                        tx_q <= status_byte;
                    end
                end
            end
        end
    end

    chk_top_bit:     assert property (opc_done && !busy_q
                                      && (rx_next & eeprom_seq_pkg::OP_RW_MASK)
                                      == eeprom_seq_pkg::OP_READ
                                      |=> addr_q[8] == $past(rx_q[2]))
        else $error("address top bit not taken from opcode");
    chk_read_advance: assert property (sck_rise && state_q == eeprom_seq_pkg::ST_RDATA
                                       && tx_cnt_q == 3'h7
                                       |=> addr_q == $past(addr_q) + 9'h001)
        else $error("read address did not advance by one");
    chk_page_wrap:   assert property (sck_fall && state_q == eeprom_seq_pkg::ST_WDATA
                                      && bit_cnt_q == 3'h7
                                      |=> addr_q[8:2] == $past(addr_q[8:2]))
        else $error("write address left its page");
    chk_latch_sel:   assert property (opc_done && rx_next == eeprom_seq_pkg::OP_LATCH_SET
                                      |=> state_q == eeprom_seq_pkg::ST_IGNORE && wel_q)
        else $error("latch set did not close the selection");

    // Output enable follows selection, pause and read phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            so_oe_q <= 1'b0;
        end else begin
            // Enable rises together with the first data bit
            so_oe_q <= ~cs_s & hold_s & (out_active_q | (sck_rise
                       & (state_q == eeprom_seq_pkg::ST_RDATA
                          || state_q == eeprom_seq_pkg::ST_SREAD)));
        end
    end

    chk_deselect_off: assert property (cs_s |=> !so_oe_q)
        else $error("output driven while deselected");
    chk_pause_off:    assert property (!hold_s |=> !so_oe_q)
        else $error("output driven while paused");

    // Write latch: set wins over clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wel_q <= 1'b0;
        end else if (opc_done && rx_next == eeprom_seq_pkg::OP_LATCH_SET) begin
            wel_q <= 1'b1;
        end else if (busy_end
                     || (opc_done && rx_next == eeprom_seq_pkg::OP_LATCH_CLEAR)) begin
            wel_q <= 1'b0;
        end
    end

    // Self-timed write engine
    assign busy_end = busy_q & timer_done_q & ~load_active_q & ~fifo_out_valid;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q        <= 1'b0;
            timer_q       <= '0;
            timer_done_q  <= 1'b0;
            load_active_q <= 1'b0;
            load_idx_q    <= 2'h0;
            sts_pend_q    <= 1'b0;
            bp_q          <= eeprom_seq_pkg::PROT_NONE;
        end else if (start) begin
            busy_q        <= 1'b1;
            timer_q       <= '0;
            timer_done_q  <= 1'b0;
            load_active_q <= commit_arr;
            load_idx_q    <= 2'h0;
            sts_pend_q    <= commit_sts;
        end else if (busy_q) begin
            if (!timer_done_q) begin
                timer_q <= timer_q + TW'(1);
                if (timer_q == TW'(WRITE_CYCLES - 1)) begin
                    timer_done_q <= 1'b1;
                end
            end
            if (load_active_q && (fifo_in_ready || !page_valid_q[load_idx_q])) begin
                load_idx_q <= load_idx_q + 2'h1;
                if (load_idx_q == 2'h3) begin
                    load_active_q <= 1'b0;
                end
            end
            if (busy_end) begin
                busy_q     <= 1'b0;
                sts_pend_q <= 1'b0;
                if (sts_pend_q) begin
                    bp_q <= sw_data_q[eeprom_seq_pkg::ST_PROT_LO_POS +: 2];
                end
            end
        end
    end

    chk_busy_cause: assert property ($rose(busy_q) |-> $past(start))
        else $error("busy rose without a qualified write");
    chk_busy_len:   assert property ($fell(busy_q) |-> $past(timer_done_q) && !wel_q)
        else $error("busy ended early or latch left set");

    assign fifo_in_valid = load_active_q & page_valid_q[load_idx_q];
    assign fifo_in_data  = {addr_q[8:2], load_idx_q, page_buf_q[load_idx_q]};

    write_fifo #(
        .WIDTH (eeprom_seq_pkg::FIFO_W),
        .DEPTH (eeprom_seq_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (fifo_in_valid),
        .in_data   (fifo_in_data),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_ready (timer_done_q),
        .out_data  (fifo_out_data)
    );

    // Array cells are updated only after the busy timer expires
    always_ff @(posedge ref_clk) begin
        if (fifo_out_valid && timer_done_q) begin
            mem_q[fifo_out_data[eeprom_seq_pkg::FIFO_W-1 -: eeprom_seq_pkg::ADDR_W]]
                <= fifo_out_data[eeprom_seq_pkg::DATA_W-1:0];
        end
    end

    assign so_out           = so_q;
    assign so_oe            = so_oe_q;
    assign write_busy_flag  = busy_q;
    assign write_latch_flag = wel_q;
endmodule : spi_eeprom_command_sequencer

// ### dv/spi_host_model.sv
// Host side of the serial link: select, mode 1 byte slots, pause.
// Assumes callers start on a 3 ns offset from the 50 MHz clock edges.
`timescale 1ns/1ps
module spi_host_model (
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n,
    input  wire logic so_out,
    input  wire logic so_oe
);
    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
    end
    task automatic sel();
        #200 cs_n = 1'b0;
        #100;
    endtask : sel
    task automatic desel();
        #100 cs_n = 1'b1;
        si = ~si;
        #300;
    endtask : desel
    // Clock idles low; bit driven mid low phase, taken on the fall
    // Released output reads as the inverse of its last value
    task automatic xfer(input logic [7:0] tx, input int nbits, input int pz,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            #40 si = tx[i];
            #40 sck = 1'b1;
            if (i == pz) begin
                #20 hold_n = 1'b0;
                #100 sck = 1'b0;
                si = ~si;
                #100 sck = 1'b1;
                si = tx[i];
                #100 hold_n = 1'b1;
                #100;
            end
            #70 rx[i] = so_oe ? so_out : ~so_out;
            #10 sck = 1'b0;
        end
    endtask : xfer
endmodule : spi_host_model

// ### dv/tb_spi_eeprom_command_sequencer.sv
// Self-checking bench for the command sequencer against a byte-array model.
// Assumes the host model drives the link pins; short write time parameter.
`timescale 1ns/1ps
module tb_spi_eeprom_command_sequencer;
    localparam int WCYC = 400;
    logic       ref_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       wp_n    = 1'b1;
    logic       cs_n, sck, si, hold_n, so_out, so_oe, busy, latch;
    int         miscompares = 0;
    int         num_checks  = 0;
    int         seed        = 71;
    logic [7:0] mem [512];
    logic [7:0] rx;
    logic [1:0] bp     = 2'h0;
    logic       mlatch = 1'b0;
    logic [8:0] tgt [3] = '{9'h0fc, 9'h17c, 9'h1fc};
    logic [1:0] bps [4] = '{2'h1, 2'h2, 2'h3, 2'h0};

    always #10 ref_clk = ~ref_clk;

    spi_eeprom_command_sequencer #(.WRITE_CYCLES(WCYC)) spi_eeprom_command_sequencer_inst (
        .ref_clk(ref_clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
        .write_busy_flag(busy), .write_latch_flag(latch));
    spi_host_model spi_host_model_inst (
        .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so_out(so_out),
        .so_oe(so_oe));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic tx(input logic [7:0] b, input int n = 8, input int pz = -1);
        spi_host_model_inst.xfer(b, n, pz, rx);
    endtask : tx
    task automatic cmd(input logic [7:0] op);
        spi_host_model_inst.sel();
        tx(op);
        spi_host_model_inst.desel();
        if (op == eeprom_seq_pkg::OP_LATCH_SET) mlatch = 1'b1;
        if (op == eeprom_seq_pkg::OP_LATCH_CLEAR) mlatch = 1'b0;
        check("latch", latch, mlatch);
    endtask : cmd
    task automatic status(input logic [7:0] exp);
        spi_host_model_inst.sel();
        tx(eeprom_seq_pkg::OP_STATUS_READ);
        tx(8'h00);
        spi_host_model_inst.desel();
        check("status", rx, exp);
    endtask : status
    // Busy must follow only a qualified write; latch drops at its end
    task automatic settle(input logic go);
        repeat (10) @(posedge ref_clk);
        #3 check("busy", busy, go);
        if (go) begin
            status(8'hff);
            for (int t = 0; t < 800 && busy !== 1'b0; t++) @(posedge ref_clk);
            #3 mlatch = 1'b0;
        end
        check("busy_end", busy, 1'b0);
        check("latch_end", latch, mlatch);
        status({4'h0, bp, mlatch, 1'b0});
    endtask : settle
    task automatic wr(input logic [8:0] a, input int n, input int pz, input int cut,
                      input logic pre);
        logic [7:0] d;
        logic       go;
        go = mlatch && wp_n && cut == 8 && !pre && !(bp != 2'h0 &&
             a >= (bp == 2'h1 ? 9'h180 : bp == 2'h2 ? 9'h100 : 9'h000));
        spi_host_model_inst.sel();
        if (pre) tx(eeprom_seq_pkg::OP_LATCH_SET);
        tx(eeprom_seq_pkg::OP_WRITE | {4'h0, a[8], 3'h0});
        tx(a[7:0]);
        for (int k = 0; k < n; k++) begin
            d = 8'($random(seed));
            tx(d, (k == n - 1) ? cut : 8, (k == 0) ? pz : -1);
            if (go) mem[{a[8:2], a[1:0] + 2'(k)}] = d;
        end
        spi_host_model_inst.desel();
        settle(go);
    endtask : wr
    task automatic sw(input logic [1:0] nb);
        cmd(eeprom_seq_pkg::OP_LATCH_SET);
        spi_host_model_inst.sel();
        tx(eeprom_seq_pkg::OP_STATUS_WRITE);
        tx({4'h0, nb, 2'h0});
        spi_host_model_inst.desel();
        bp = nb;
        settle(1'b1);
    endtask : sw
    task automatic rd(input logic [8:0] a, input int n);
        spi_host_model_inst.sel();
        tx(eeprom_seq_pkg::OP_READ | {4'h0, a[8], 3'h0});
        tx(a[7:0]);
        for (int k = 0; k < n; k++) begin
            tx(8'h00);
            check("read", rx, mem[9'(a + k)]);
            check("so_oe_on", so_oe, 1'b1);
        end
        spi_host_model_inst.desel();
        check("so_oe", so_oe, 1'b0);
    endtask : rd

    initial begin
        #1_500_000 miscompares++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        #3 reset_n = 1'b1;
        repeat (10) @(posedge ref_clk);
        #3 check("so_oe", so_oe, 1'b0);
        check("latch", latch, 1'b0);
        status(8'h00);
        $display("test power-up done");
        cmd(eeprom_seq_pkg::OP_LATCH_SET);
        wr(9'h1fc, 6, 3, 8, 1'b0);
        cmd(eeprom_seq_pkg::OP_LATCH_SET);
        wr(9'h000, 4, -1, 8, 1'b0);
        rd(9'h1fd, 6);
        $display("test page write and wrap read done");
        cmd(eeprom_seq_pkg::OP_LATCH_SET);
        wr(9'h050, 1, -1, 4, 1'b0);
        wr(9'h050, 1, -1, 8, 1'b1);
        cmd(eeprom_seq_pkg::OP_LATCH_CLEAR);
        wr(9'h050, 1, -1, 8, 1'b0);
        $display("test refused writes done");
        foreach (bps[i]) begin
            sw(bps[i]);
            foreach (tgt[j]) begin
                cmd(eeprom_seq_pkg::OP_LATCH_SET);
                wr(tgt[j], 1, -1, 8, 1'b0);
            end
        end
        cmd(eeprom_seq_pkg::OP_LATCH_SET);
        wp_n = 1'b0;
        wr(9'h0fc, 1, -1, 8, 1'b0);
        wp_n = 1'b1;
        foreach (tgt[j]) rd(tgt[j], 1);
        $display("test protection done");
        end_sim();
    end
endmodule : tb_spi_eeprom_command_sequencer
